// ---- include/xps_pkg.sv ----
// constants and types for the extension bus peripheral select block
// assumes a 16-bit cpu core bus with byte addresses of 24 bits
// Behaviour
// [R1] rtc window goes on-chip only with global enable and bit 4
// [R2] extra pwm window goes on-chip only with global enable and bit 6
// [R3] extra async serial window goes on-chip only with global enable and bit 7
// [R4] extra sync serial window goes on-chip only with global enable and bit 8
// [R5] extra i2c window goes on-chip only with global enable and bit 9
// [R6] misc features window goes on-chip only with global enable and bit 10
// [R7] each peripheral access takes exactly two wait states, no tristate wait
// [R8] peripheral windows use demultiplexed addresses, 16-bit words only
// [R9] with a can module enabled only four segment address lines are driven; the code needs global enable and drives none under port seven select
// [R10] port seven select swaps shared pins and limits memory to 64 Kbytes
// [R11] a peripheral disabled at global enable claims no space, pins or interrupts
// [R12] after end of init, clocks of disabled peripherals stop except rams and misc
// [R13] peripherals gated off after end of init receive no reset
// [R14] software copies the enable register into the emulation copy register
// [R15] software writes the emulation copy last, after both config registers
// [R16] a disabled window goes external only if all shared-range enables are zero
// [R17] enable register is readable and writable; a set bit enables that module
// [R18] enable register writes are ignored once global enable is set
// [R19] after reset only the first can and small ram are enabled
// [R20] addresses outside enabled windows go unchanged to the external bus; the code keeps shared-range ones internal while any sharer is enabled
package xps_pkg;
	localparam int          XPS_AW            = 24;
	localparam int          XPS_DW            = 16;
	localparam int          XPS_NPER          = 16;
	localparam logic [15:0] XPS_EN_RESET      = 16'h0005;
	localparam logic [15:0] XPS_EN_WMASK      = 16'h07DF;
	localparam logic [15:0] XPS_EN_CLK_KEEP   = 16'h040C;
	localparam logic [15:0] XPS_EN_SHARED     = 16'h07D3;
	localparam int          XPS_BIT_CAN1      = 0;
	localparam int          XPS_BIT_CAN2      = 1;
	localparam int          XPS_BIT_RTC       = 4;
	localparam int          XPS_BIT_PWM       = 6;
	localparam int          XPS_BIT_ASC       = 7;
	localparam int          XPS_BIT_SSC       = 8;
	localparam int          XPS_BIT_I2C       = 9;
	localparam int          XPS_BIT_MISC      = 10;
	localparam logic [23:0] XPS_WIN_CAN1      = 24'h00EF00;
	localparam logic [23:0] XPS_WIN_CAN2      = 24'h00EE00;
	localparam logic [23:0] XPS_WIN_RTC       = 24'h00ED00;
	localparam logic [23:0] XPS_WIN_PWM       = 24'h00EC00;
	localparam logic [23:0] XPS_WIN_ASC       = 24'h00E900;
	localparam logic [23:0] XPS_WIN_SSC       = 24'h00E800;
	localparam logic [23:0] XPS_WIN_I2C       = 24'h00EA00;
	localparam logic [23:0] XPS_WIN_MISC      = 24'h00EB00;
	localparam logic [23:0] XPS_SHARED_BASE   = 24'h00E800;
	localparam logic [23:0] XPS_SHARED_MASK   = 24'hFFF800;
	localparam logic [23:0] XPS_WIN_MASK      = 24'hFFFF00;
	localparam int          XPS_WAIT_STATES   = 2;
	localparam int          XPS_CPU_MHZ       = 40;
	localparam int          XPS_CYCLE_NS      = 100;
	localparam int          XPS_CLK_MHZ       = 100;
	// one cpu clock at 40 MHz, in core clocks at 100 MHz, rounded up
	localparam int          XPS_WS_CYC        = (XPS_CLK_MHZ + XPS_CPU_MHZ - 1) / XPS_CPU_MHZ;
	localparam logic [7:0]  XPS_SEG_ALL       = 8'hFF;
	localparam logic [7:0]  XPS_SEG_FOUR      = 8'h0F;
	localparam logic [7:0]  XPS_SEG_NONE      = 8'h00;

	typedef enum logic [1:0] {
		XPS_IDLE = 2'b00,
		XPS_WAIT = 2'b01,
		XPS_DONE = 2'b10
	} xps_state_t;

	// window match for a 256-byte peripheral window
	function automatic logic xps_in_win(input logic [23:0] a, input logic [23:0] base);
		xps_in_win = ((a & XPS_WIN_MASK) == base);
	endfunction : xps_in_win
endpackage : xps_pkg

// ---- include/xps_cyc_if.sv ----
// request and completion signals between the decoder and the cycle timer
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface xps_cyc_if;
	logic start;
	logic done;
	logic busy;
	modport ctrl  (output start, input done, input busy);
	modport timer (input start, output done, output busy);
endinterface : xps_cyc_if

// ---- rtl/xps_wait_timer.sv ----
// times one extension bus cycle: fixed wait states, no tristate wait
// assumes start is a one-cycle pulse only while busy is low
`timescale 1ns/1ps
module xps_wait_timer
	import xps_pkg::*;
#(
	parameter int WAIT_CYC = XPS_WAIT_STATES * XPS_WS_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	xps_cyc_if.timer  cyc
);
	initial begin
		if (WAIT_CYC < 1 || WAIT_CYC > 255) begin
			$error("xps_wait_timer: WAIT_CYC out of range");
		end
	end

	typedef struct packed {
		logic [7:0] cnt;
		logic       busy;
		logic       done;
	} xps_tmr_t;

	xps_tmr_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (s_q.busy) begin
			if (s_q.cnt == 8'h00) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 8'h01;
			end
		end else if (cyc.start) begin
			// address phase plus exactly the wait states
			s_d.busy = 1'b1; // R7
			s_d.cnt  = 8'(WAIT_CYC);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cyc.done = s_q.done;
	assign cyc.busy = s_q.busy;
endmodule : xps_wait_timer

// ---- rtl/xps_select.sv ----
// extension bus peripheral select: enable register, window decode, clock gating
// assumes the cpu holds a request until ACK_OUT and issues no new one before
`timescale 1ns/1ps
module xps_select
	import xps_pkg::*;
#(
	parameter int AW = XPS_AW,
	parameter int DW = XPS_DW
) (
	input  wire logic          CORE_CLK_IN,
	input  wire logic          RESETN_IN,
	input  wire logic          REQ_IN,
	input  wire logic          WR_IN,
	input  wire logic          WORD_IN,
	input  wire logic [AW-1:0] ADDR_IN,
	input  wire logic [DW-1:0] WDATA_IN,
	input  wire logic          ENREG_SEL_IN,
	input  wire logic          GLOBAL_EXTENSION_ENABLE_IN,
	input  wire logic          END_OF_INIT_INSTRUCTION_IN,
	input  wire logic          PORT_SEVEN_PIN_SELECT_IN,
	input  wire logic [DW-1:0] XRDATA_IN,
	output logic      [DW-1:0] RDATA_OUT,
	output logic               ACK_OUT,
	output logic               BYTE_ERR_OUT,
	output logic [XPS_NPER-1:0] XSEL_OUT,
	output logic      [AW-1:0] XADDR_OUT,
	output logic      [DW-1:0] XWDATA_OUT,
	output logic               XWR_OUT,
	output logic               EXT_REQ_OUT,
	output logic      [AW-1:0] EXT_ADDR_OUT,
	output logic      [7:0]    SEG_LINES_EN_OUT,
	output logic               PORT7_ON_PINS_OUT,
	output logic               EXT_64K_LIMIT_OUT,
	output logic [XPS_NPER-1:0] PER_CLK_EN_OUT,
	output logic [XPS_NPER-1:0] PER_RST_EN_OUT,
	output logic [XPS_NPER-1:0] PER_CLAIM_OUT,
	output logic [DW-1:0]      PERIPHERAL_ENABLE_REGISTER_OUT
);
	initial begin
		if (AW != XPS_AW || DW != XPS_DW) begin
			$error("xps_select: only 24-bit address and 16-bit data supported");
		end
	end

	typedef struct packed {
		xps_state_t                st;
		logic [15:0]               en;
		logic                      gated;
		logic [DW-1:0]             rdata;
		logic                      ack;
		logic                      byte_err;
		logic [XPS_NPER-1:0]       xsel;
		logic [AW-1:0]             xaddr;
		logic [DW-1:0]             xwdata;
		logic                      xwr;
		logic                      ext_req;
		logic [AW-1:0]             ext_addr;
		logic [7:0]                seg_en;
		logic                      p7;
		logic                      lim64;
		logic [XPS_NPER-1:0]       clk_en;
		logic [XPS_NPER-1:0]       rst_en;
		logic [XPS_NPER-1:0]       claim;
	} xps_state_all_t;

	xps_state_all_t s_q, s_d;
	xps_cyc_if      cyc ();

	logic [XPS_NPER-1:0] hit;
	logic [XPS_NPER-1:0] active;
	logic                in_shared;
	logic                any_shared;

	xps_wait_timer xps_wait_timer_i (
		.clk   (CORE_CLK_IN),
		.rst_n (RESETN_IN),
		.cyc   (cyc)
	);

	// per-bit window hits; unused bits never match
	always_comb begin
		hit = '0;
		hit[XPS_BIT_CAN1] = xps_in_win(ADDR_IN, XPS_WIN_CAN1);
		hit[XPS_BIT_CAN2] = xps_in_win(ADDR_IN, XPS_WIN_CAN2);
		hit[XPS_BIT_RTC]  = xps_in_win(ADDR_IN, XPS_WIN_RTC);  // R1
		hit[XPS_BIT_PWM]  = xps_in_win(ADDR_IN, XPS_WIN_PWM);  // R2
		hit[XPS_BIT_ASC]  = xps_in_win(ADDR_IN, XPS_WIN_ASC);  // R3
		hit[XPS_BIT_SSC]  = xps_in_win(ADDR_IN, XPS_WIN_SSC);  // R4
		hit[XPS_BIT_I2C]  = xps_in_win(ADDR_IN, XPS_WIN_I2C);  // R5
		hit[XPS_BIT_MISC] = xps_in_win(ADDR_IN, XPS_WIN_MISC); // R6
	end

	// a window is live only with the global enable; disabled ones claim nothing
	assign active     = GLOBAL_EXTENSION_ENABLE_IN ? (s_q.en & XPS_EN_SHARED) : '0; // R11
	assign in_shared  = ((ADDR_IN & XPS_SHARED_MASK) == XPS_SHARED_BASE);
	assign any_shared = |active;

	always_comb begin
		s_d          = s_q;
		s_d.ack      = 1'b0;
		s_d.byte_err = 1'b0;
		s_d.ext_req  = 1'b0;
		cyc.start    = 1'b0;

		// enable register: read any time, writes frozen after global enable
		if (ENREG_SEL_IN && REQ_IN && WR_IN && !GLOBAL_EXTENSION_ENABLE_IN) begin // R18
			s_d.en = WDATA_IN & XPS_EN_WMASK; // R17
		end

		unique case (s_q.st)
			XPS_IDLE: begin
				// never start a cycle while the timer still runs the previous one
				if (REQ_IN && !ENREG_SEL_IN && !s_q.ack && !cyc.busy) begin
					if (|(hit & active)) begin
						if (!WORD_IN) begin
							// byte access to a word-only window: refused, answered at once
							s_d.byte_err = 1'b1; // R8
							s_d.ack      = 1'b1;
						end else begin
							s_d.xsel   = hit & active;
							s_d.xaddr  = ADDR_IN; // R8
							s_d.xwdata = WDATA_IN;
							s_d.xwr    = WR_IN;
							cyc.start  = 1'b1; // R7
							s_d.st     = XPS_WAIT;
						end
					end else if (in_shared && any_shared) begin
						// shared range stays internal while any sharer is on: no external cycle
						s_d.rdata = '0; // R16
						s_d.ack   = 1'b1;
					end else begin
						s_d.ext_req  = 1'b1; // R20
						s_d.ext_addr = ADDR_IN;
						s_d.ack      = 1'b1;
						s_d.rdata    = '0;
					end
				end else if (REQ_IN && ENREG_SEL_IN && !s_q.ack) begin
					s_d.rdata = s_q.en; // R17
					s_d.ack   = 1'b1;
				end
			end
			XPS_WAIT: begin
				if (cyc.done) begin
					s_d.rdata = s_q.xwr ? '0 : XRDATA_IN;
					s_d.ack   = 1'b1;
					s_d.xsel  = '0;
					s_d.xwr   = 1'b0;
					s_d.st    = XPS_DONE;
				end
			end
			XPS_DONE: begin
				s_d.st = XPS_IDLE;
			end
			default: begin
				s_d.st = XPS_IDLE;
			end
		endcase

		// segment lines: four with any can enabled under global enable, none when port seven takes the pins
		if (PORT_SEVEN_PIN_SELECT_IN) begin
			s_d.seg_en = XPS_SEG_NONE; // R10
		end else if (GLOBAL_EXTENSION_ENABLE_IN && (s_q.en[XPS_BIT_CAN1] || s_q.en[XPS_BIT_CAN2])) begin
			s_d.seg_en = XPS_SEG_FOUR; // R9
		end else begin
			s_d.seg_en = XPS_SEG_ALL;
		end
		s_d.p7    = PORT_SEVEN_PIN_SELECT_IN; // R10
		s_d.lim64 = PORT_SEVEN_PIN_SELECT_IN; // R10
		s_d.claim = active;                   // R11

		// gating is latched at end of init and never undone until reset
		if (END_OF_INIT_INSTRUCTION_IN) begin
			s_d.gated = 1'b1;
		end
		if (s_q.gated) begin
			s_d.clk_en = s_q.en | XPS_EN_CLK_KEEP; // R12
			s_d.rst_en = s_q.en | XPS_EN_CLK_KEEP; // R13
		end else begin
			s_d.clk_en = '1;
			s_d.rst_en = '1;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESETN_IN) begin
			s_q        <= '0;
			s_q.st     <= XPS_IDLE;
			s_q.en     <= XPS_EN_RESET; // R19
			s_q.seg_en <= XPS_SEG_ALL;
			s_q.clk_en <= '1;
			s_q.rst_en <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA_OUT                      = s_q.rdata;
	assign ACK_OUT                        = s_q.ack;
	assign BYTE_ERR_OUT                   = s_q.byte_err;
	assign XSEL_OUT                       = s_q.xsel;
	assign XADDR_OUT                      = s_q.xaddr;
	assign XWDATA_OUT                     = s_q.xwdata;
	assign XWR_OUT                        = s_q.xwr;
	assign EXT_REQ_OUT                    = s_q.ext_req;
	assign EXT_ADDR_OUT                   = s_q.ext_addr;
	assign SEG_LINES_EN_OUT               = s_q.seg_en;
	assign PORT7_ON_PINS_OUT              = s_q.p7;
	assign EXT_64K_LIMIT_OUT              = s_q.lim64;
	assign PER_CLK_EN_OUT                 = s_q.clk_en;
	assign PER_RST_EN_OUT                 = s_q.rst_en;
	assign PER_CLAIM_OUT                  = s_q.claim;
	assign PERIPHERAL_ENABLE_REGISTER_OUT = s_q.en;
endmodule : xps_select

// ---- verification/xps_select_properties.sv ----
// port assertions for the extension bus peripheral select
// assumes one clock and a synchronous active-low reset on the select block
`timescale 1ns/1ps
module xps_select_properties
	import xps_pkg::*;
#(
	parameter int AW = XPS_AW,
	parameter int DW = XPS_DW
) (
	input wire logic                CORE_CLK_IN,
	input wire logic                RESETN_IN,
	input wire logic                GLOBAL_EXTENSION_ENABLE_IN,
	input wire logic                PORT_SEVEN_PIN_SELECT_IN,
	input wire logic                ACK_OUT,
	input wire logic                BYTE_ERR_OUT,
	input wire logic                EXT_REQ_OUT,
	input wire logic [XPS_NPER-1:0] XSEL_OUT,
	input wire logic [7:0]          SEG_LINES_EN_OUT,
	input wire logic                PORT7_ON_PINS_OUT,
	input wire logic                EXT_64K_LIMIT_OUT,
	input wire logic [XPS_NPER-1:0] PER_CLK_EN_OUT,
	input wire logic [XPS_NPER-1:0] PER_RST_EN_OUT,
	input wire logic [XPS_NPER-1:0] PER_CLAIM_OUT,
	input wire logic [DW-1:0]       PERIPHERAL_ENABLE_REGISTER_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	logic [15:0] en;
	logic        glob;
	assign en = PERIPHERAL_ENABLE_REGISTER_OUT[15:0];
	assign glob = GLOBAL_EXTENSION_ENABLE_IN;
	// registered outputs lag one edge, so compare only on settled inputs
	sequence settled_s;
		$past(RESETN_IN) && glob && $past(glob) && $stable(en);
	endsequence
	ack_pulse_a: assert property (ACK_OUT |=> !ACK_OUT) else $error("ack too long");
	wait_len_a: assert property ($rose(|XSEL_OUT) |-> (|XSEL_OUT)[*8] ##1 (ACK_OUT && XSEL_OUT == '0))
		else $error("peripheral cycle length wrong");
	sel_enabled_a: assert property (|XSEL_OUT |-> glob && (XSEL_OUT & ~en) == '0)
		else $error("disabled window selected");
	sel_onehot_a: assert property ($onehot0(XSEL_OUT)) else $error("select not one-hot");
	byte_refuse_a: assert property (BYTE_ERR_OUT |-> ACK_OUT && XSEL_OUT == '0) else $error("byte not refused");
	enreg_lock_a: assert property ($past(RESETN_IN) && glob && $past(glob) |-> $stable(en))
		else $error("enable register changed while locked");
	claim_a: assert property (settled_s |-> PER_CLAIM_OUT == (en & XPS_EN_SHARED)) else $error("claim wrong");
	seg_can_a: assert property (settled_s ##0 (|en[1:0] && !PORT_SEVEN_PIN_SELECT_IN
		&& !$past(PORT_SEVEN_PIN_SELECT_IN)) |-> SEG_LINES_EN_OUT == XPS_SEG_FOUR) else $error("segment lines wrong");
	port7_a: assert property ($past(RESETN_IN) |-> PORT7_ON_PINS_OUT == $past(PORT_SEVEN_PIN_SELECT_IN)
		&& EXT_64K_LIMIT_OUT == PORT7_ON_PINS_OUT) else $error("port seven select wrong");
	clk_keep_a: assert property ((PER_CLK_EN_OUT & XPS_EN_CLK_KEEP) == XPS_EN_CLK_KEEP
		&& PER_RST_EN_OUT == PER_CLK_EN_OUT) else $error("kept clock gated");
	ext_fwd_a: assert property (EXT_REQ_OUT |-> ACK_OUT && XSEL_OUT == '0) else $error("external with select");
	cover property ($rose(|XSEL_OUT));
	cover property (BYTE_ERR_OUT);
	cover property (EXT_REQ_OUT);
endmodule : xps_select_properties

bind xps_select xps_select_properties #(.AW(AW), .DW(DW)) xps_select_properties_i (.*);

// ---- verification/xps_periph_model.sv ----
// behavioural bank of extension peripherals on the far side of the select
// assumes read data is sampled while a select line is high
`timescale 1ns/1ps
module xps_periph_model
	import xps_pkg::*;
(
	input  wire logic                clk_in,
	input  wire logic [XPS_NPER-1:0] sel_in,
	input  wire logic [XPS_AW-1:0]   addr_in,
	output logic      [XPS_DW-1:0]   rdata_out
);
	logic [XPS_DW-1:0] last_q = '0;
	always_ff @(posedge clk_in) begin
		if (|sel_in) begin
			last_q <= rdata_out;
		end
	end
	// released bus shows the inverse of its last word so stale data never matches
	assign rdata_out = (|sel_in) ? (addr_in[15:0] ^ 16'h5A5A) : ~last_q;
endmodule : xps_periph_model

// ---- verification/xps_select_test.sv ----
// self-checking bench for the extension bus peripheral select
// assumes the select block, its timer and the peripheral model are compiled first
`timescale 1ns/1ps
module xps_select_test
	import xps_pkg::*;
;
	logic        clk, rst_n, req, wr, word, sel, glob, end_of_init_instruction, p7;
	logic [23:0] addr, xaddr, eaddr_o, eaddr;
	logic [15:0] wdata, xrdata, rdata, rd, enreg, xwdata, cap_wd, emu_copy;
	logic [15:0] xsel, clken, rsten, claim;
	logic [7:0]  seg;
	logic        ack, berr_o, ext_o, p7pins, lim64, berr, ext, xwr, cap_wr;
	int          err_count, compares;
	xps_select xps_select_i (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .REQ_IN(req), .WR_IN(wr), .WORD_IN(word),
		.ADDR_IN(addr), .WDATA_IN(wdata), .ENREG_SEL_IN(sel), .GLOBAL_EXTENSION_ENABLE_IN(glob),
		.END_OF_INIT_INSTRUCTION_IN(end_of_init_instruction), .PORT_SEVEN_PIN_SELECT_IN(p7), .XRDATA_IN(xrdata),
		.RDATA_OUT(rdata), .ACK_OUT(ack), .BYTE_ERR_OUT(berr_o), .XSEL_OUT(xsel), .XADDR_OUT(xaddr),
		.XWDATA_OUT(xwdata), .XWR_OUT(xwr), .EXT_REQ_OUT(ext_o), .EXT_ADDR_OUT(eaddr_o), .SEG_LINES_EN_OUT(seg),
		.PORT7_ON_PINS_OUT(p7pins), .EXT_64K_LIMIT_OUT(lim64), .PER_CLK_EN_OUT(clken),
		.PER_RST_EN_OUT(rsten), .PER_CLAIM_OUT(claim), .PERIPHERAL_ENABLE_REGISTER_OUT(enreg));
	xps_periph_model xps_periph_model_i (.clk_in(clk), .sel_in(xsel), .addr_in(xaddr), .rdata_out(xrdata));
	// what the peripheral saw last while selected
	always @(posedge clk) begin
		if (|xsel) begin
			{cap_wr, cap_wd} <= {xwr, xwdata};
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// one request held until its answer, then three idle cycles before the next
	task automatic acc(input logic w, input logic wd, input logic s, input logic [23:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		{req, wr, word, sel, addr, wdata} <= {1'b1, w, wd, s, a, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		{rd, berr, ext, eaddr} = {rdata, berr_o, ext_o, eaddr_o};
		req <= 1'b0;
		if (n >= 20) chk("ack", 24'h0, 24'h1);
		repeat (2) @(posedge clk);
	endtask : acc
	task automatic t_reset();
		chk("enreg", enreg, 16'h0005);
		chk("clken", clken, 16'hFFFF);
		$display("reset test done");
	endtask : t_reset
	task automatic t_enreg();
		acc(1, 1, 1, 0, 16'hFFFF);
		acc(0, 1, 1, 0, 0);
		chk("enreg rd", rd, 16'h07DF);
		acc(1, 1, 1, 0, 16'h03D5);
		glob <= 1'b1;
		acc(1, 1, 1, 0, 16'h0000);
		acc(0, 1, 1, 0, 0);
		chk("enreg lock", rd, 16'h03D5);
		// software duty: copy written last, after both configuration registers
		emu_copy = enreg;
		chk("emu copy", emu_copy, 16'h03D5);
		chk("claim", claim, 16'h03D1);
		chk("seg", seg, 8'h0F);
		$display("enable register test done");
	endtask : t_enreg
	task automatic t_periph();
		logic [23:0] win [5] = '{24'h00ED00, 24'h00EC00, 24'h00E900, 24'h00E800, 24'h00EA02};
		foreach (win[i]) begin
			acc(0, 1, 0, win[i], 0);
			chk("periph rd", rd, win[i][15:0] ^ 16'h5A5A);
			chk("periph wr", cap_wr, 1'b0);
		end
		acc(0, 0, 0, 24'h00ED00, 0);
		chk("byte err", berr, 1'b1);
		$display("peripheral test done");
	endtask : t_periph
	task automatic t_route();
		acc(0, 1, 0, 24'h00EB00, 0);
		chk("shared ext", ext, 1'b0);
		acc(0, 1, 0, 24'h123456, 0);
		chk("ext req", ext, 1'b1);
		chk("ext addr", eaddr, 24'h123456);
		$display("routing test done");
	endtask : t_route
	task automatic t_gate();
		@(posedge clk);
		{end_of_init_instruction, p7} <= 2'b11;
		repeat (3) @(posedge clk);
		chk("clk gate", clken, 16'h07DD);
		chk("rst gate", rsten, 16'h07DD);
		chk("seg p7", seg, 8'h00);
		chk("limit", lim64, 1'b1);
		chk("p7 pins", p7pins, 1'b1);
		$display("gating test done");
	endtask : t_gate
	// mid-run reset, then a fresh enable value and the global enable
	task automatic rearm(input logic [15:0] v);
		@(posedge clk);
		{rst_n, glob, end_of_init_instruction, p7} <= 4'b0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		acc(1, 1, 1, 0, v);
		glob <= 1'b1;
		chk("clken rearm", clken, 16'hFFFF);
	endtask : rearm
	task automatic t_reinit();
		rearm(16'h0400);
		acc(0, 1, 0, 24'h00EB00, 0);
		chk("misc rd", rd, 16'hEB00 ^ 16'h5A5A);
		acc(1, 1, 0, 24'h00EB04, 16'hBEEF);
		chk("misc wdata", cap_wd, 16'hBEEF);
		chk("misc wr", cap_wr, 1'b1);
		chk("wr rdata", rd, 16'h0000);
		acc(0, 1, 0, 24'h00EC00, 0);
		chk("pwm off ext", ext, 1'b0);
		chk("seg no can", seg, 8'hFF);
		chk("claim misc", claim, 16'h0400);
		chk("p7 pins off", p7pins, 1'b0);
		rearm(16'h0000);
		acc(0, 1, 0, 24'h00E800, 0);
		chk("all off ext", ext, 1'b1);
		chk("all off addr", eaddr, 24'h00E800);
		chk("claim none", claim, 16'h0000);
		$display("re-initialisation test done");
	endtask : t_reinit
	initial begin
		{rst_n, req, wr, word, sel, glob, end_of_init_instruction, p7, addr, wdata} = '0;
		{err_count, compares} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_enreg();
		t_periph();
		t_route();
		t_gate();
		t_reinit();
		end_sim();
	end
	initial begin
		repeat (2000) @(posedge clk);
		err_count++;
		end_sim();
	end
endmodule : xps_select_test
